// ===== rtl/dec_if.sv
// Purpose: Carries samples and settings to the decimator and words back.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/10ps
interface dec_if;
    logic                 run;
    logic                 sample_en;
    logic                 mod_bit;
    sdadc_pkg::osr_sel_t  osr_sel;
    sdadc_pkg::ofs_sel_t  ofs_sel;
    logic                 word_valid;
    logic [23:0]          word;
    logic                 sat;

    modport ctrl (output run, sample_en, mod_bit, osr_sel, ofs_sel, input word_valid, word, sat);
    modport dec  (input run, sample_en, mod_bit, osr_sel, ofs_sel, output word_valid, word, sat);
endinterface : dec_if

// ===== rtl/sdadc_decimator.sv
// Purpose: Counts modulator ones over one oversampling period and forms a signed 24-bit word.
// Assumes: sample_en is a one-cycle pulse per converter clock period.
// Notes:   The word is scaled to full 24-bit range, offset, then clamped.
`include "sdadc_defs.svh"
`timescale 1ns/10ps
module sdadc_decimator (
    input  wire logic clk_i,
    input  wire logic rst_i,
    dec_if.dec        dec
);
    logic [3:0]         k;
    logic [15:0]        n;
    logic [15:0]        cnt_r;
    logic [15:0]        ones_r;
    logic [15:0]        ones_f;
    logic signed [17:0] val;
    logic signed [25:0] scaled;
    logic signed [25:0] offs;
    logic signed [25:0] sum;
    logic [23:0]        word_nxt;
    logic               sat_nxt;
    logic               last;

    assign k      = sdadc_pkg::osr_log2(dec.osr_sel);
    assign n      = 16'(17'd1 << k);
    assign last   = dec.sample_en && (cnt_r == n - 16'd1);
    assign ones_f = ones_r + {15'd0, dec.mod_bit};
    assign val    = $signed({1'b0, ones_f, 1'b0}) - $signed({2'b00, n});
    assign scaled = $signed({{8{val[17]}}, val}) <<< (5'd23 - {1'b0, k});
    // The offset is a quarter of full scale per step below code 11.
    assign offs   = -$signed({24'd0, 2'd3 - dec.ofs_sel} << 21);
    assign sum    = scaled + offs;

    always_comb begin
        // Two's-complement word, clamped to the codes 0x7FFFF0 and 0x800000.
        sat_nxt  = 1'b0;
        word_nxt = sum[23:0];
        if (sum > $signed({2'b00, `SAT_POS})) begin
            word_nxt = `SAT_POS;
            sat_nxt  = 1'b1;
        end else if (sum < -$signed({2'b00, `SAT_NEG})) begin
            word_nxt = `SAT_NEG;
            sat_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !dec.run) begin
            cnt_r  <= 16'h0000;
            ones_r <= 16'h0000;
        end else if (last) begin
            cnt_r  <= 16'h0000;
            ones_r <= 16'h0000;
        end else if (dec.sample_en) begin
            cnt_r  <= cnt_r + 16'd1;
            ones_r <= ones_f;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec.word_valid <= 1'b0;
            dec.word       <= `RST_RESULT;
            dec.sat        <= 1'b0;
        end else begin
            dec.word_valid <= dec.run && last;
            if (dec.run && last) begin
                dec.word <= word_nxt;
                dec.sat  <= sat_nxt;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_WORD_BOUNDS: assert property (dec.word_valid |-> ($signed(dec.word) <= $signed(`SAT_POS)))
        else $error("Word above positive full scale.");
    AST_WORD_AFTER_LAST: assert property (dec.run && dec.sample_en && cnt_r == n - 16'd1 |=> dec.word_valid)
        else $error("No word at the end of an oversampling period.");
endmodule : sdadc_decimator

// ===== rtl/sdadc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes: Register indexes are word indexes; the byte address is four times the index.
// Notes:   Definitions only.
`ifndef SDADC_DEFS_SVH
`define SDADC_DEFS_SVH

`define IDX_CONFIG_A      8'h93
`define IDX_CONFIG_B      8'h94
`define IDX_CONFIG_C      8'h95
`define IDX_RESULT_HIGH   8'h97
`define IDX_RESULT_MID    8'h98
`define IDX_RESULT_LOW    8'h99
`define IDX_IRQ_STATUS    8'h9A
`define IDX_IRQ_MASK      8'h9B

`define CFGA_EN_BIT       0
`define CFGB_RDY_BIT      0
`define CFGB_OFS_LSB      1
`define CFGB_OSR_LSB      4
`define CFGC_KS_LSB       0
`define CFGC_INV_BIT      3
`define CFGC_CHOP_BIT     4

`define RST_CONFIG_A      8'h00
`define RST_CONFIG_B      8'h76
`define RST_CONFIG_C      8'h10
`define RST_RESULT        24'h00_0000
`define RST_IRQ           3'h0

`define IRQ_WORD_BIT      0
`define IRQ_SAT_BIT       1
`define IRQ_SETTLED_BIT   2

`define SETTLE_WORDS      3

`define SAT_POS           24'h7f_fff0
`define SAT_NEG           24'h80_0000

`define SYS_CLK_HZ        25000000
`define CONV_CLK_BASE_HZ  250000
`define CONV_HALF_CYCLES  (`SYS_CLK_HZ / (2 * `CONV_CLK_BASE_HZ))

`endif

// ===== rtl/sdadc_pkg.sv
// Purpose: Types and decoding shared by the converter control block.
// Assumes: Constants live in sdadc_defs.svh.
// Notes:   None.
package sdadc_pkg;

    typedef enum logic [1:0] {
        OFS_M75 = 2'b00,
        OFS_M50 = 2'b01,
        OFS_M25 = 2'b10,
        OFS_0   = 2'b11
    } ofs_sel_t;

    typedef enum logic [2:0] {
        KS_250K  = 3'b000,
        KS_125K  = 3'b001,
        KS_62K5  = 3'b010,
        KS_31K25 = 3'b011
    } ks_sel_t;

    typedef logic [2:0] osr_sel_t;

    // Base-two logarithm of the decimation ratio.
    function automatic logic [3:0] osr_log2(input osr_sel_t sel);
        logic [3:0] k;
        k = 4'd6;
        unique case (sel)
            3'b000: k = 4'd6;
            3'b001: k = 4'd7;
            3'b010: k = 4'd8;
            3'b011: k = 4'd10;
            3'b100: k = 4'd12;
            3'b101: k = 4'd13;
            3'b110: k = 4'd14;
            3'b111: k = 4'd15;
        endcase
        return k;
    endfunction : osr_log2

endpackage : sdadc_pkg

// ===== rtl/sigma_delta_adc_result_ctrl.sv
// Purpose: Register side and result path of a delta-sigma converter, reached over classic Wishbone.
// Assumes: 25 MHz clk_i; mod_bit_i is the modulator bitstream from the analogue front end.
// Notes:   Register index i sits at byte address 4*i; data in bits 7:0.
//
// How it works
// - Ready flag sets whenever a new word lands in the three result bytes.
// - Ready flag stays high until software writes it to zero.
// - Offset select 00/01/10/11 adds -75/-50/-25/0 percent of reference.
// - Oversampling select picks 64,128,256,1024,4096,8192,16384,32768.
// - Clock select gives 250, 125, 62.5, 31.25 kHz; 1xx reserved.
// - One word per oversampling period: converter clock over ratio.
// - First two words after enable are unsettled; third onward valid.
// - Result bytes are read-only, reset to zero, ignore writes.
// - Result bits 23:16, 15:8, 7:0 go to high, mid, low bytes.
// - Result is two's complement with bit 23 as sign.
// - Results clamp at codes 0x7FFFF0 and 0x800000.
// - Enable bit in the first config register starts the converter; resets to zero.
`include "sdadc_defs.svh"
`timescale 1ns/10ps
module sigma_delta_adc_result_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        mod_bit_i,
    output logic             conv_clk_o,
    output logic             converter_enable_o,
    output logic             chopper_enable_o,
    output logic             conv_clock_invert_o,
    output logic             irq_o
);
    dec_if dbus ();

    sdadc_decimator u_dec (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .dec   (dbus.dec)
    );

    logic                 converter_enable_r;
    logic                 conv_ready_flag_r;
    sdadc_pkg::ofs_sel_t  offset_select_r;
    sdadc_pkg::osr_sel_t  oversample_ratio_select_r;
    logic [2:0]           conv_clock_select_r;
    logic                 conv_clock_invert_r;
    logic                 chopper_enable_r;
    logic [23:0]          result_r;
    logic [2:0]           irq_status_r;
    logic [2:0]           irq_mask_r;
    logic [2:0]           irq_set;
    logic [1:0]           settle_cnt_r;
    logic                 mod_meta_r;
    logic                 mod_sync_r;
    logic [8:0]           div_cnt_r;
    logic [8:0]           half_len;
    logic                 half_tick;
    logic                 req;
    logic                 wr;
    logic [7:0]           idx;
    logic [7:0]           rd_byte;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[9:2];

    function automatic logic wr_to(input logic [7:0] target);
        return wr && (idx == target);
    endfunction : wr_to

    // Bus answer: ack one cycle after the request, then dropped for a cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {24'h00_0000, wb_we_i ? 8'h00 : rd_byte};
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            `IDX_CONFIG_A:    rd_byte = {7'd0, converter_enable_r};
            `IDX_CONFIG_B:    rd_byte = {1'b0, oversample_ratio_select_r, 1'b0, offset_select_r, conv_ready_flag_r};
            `IDX_CONFIG_C:    rd_byte = {3'd0, chopper_enable_r, conv_clock_invert_r, conv_clock_select_r};
            `IDX_RESULT_HIGH: rd_byte = result_r[23:16];
            `IDX_RESULT_MID:  rd_byte = result_r[15:8];
            `IDX_RESULT_LOW:  rd_byte = result_r[7:0];
            `IDX_IRQ_STATUS:  rd_byte = {5'd0, irq_status_r};
            `IDX_IRQ_MASK:    rd_byte = {5'd0, irq_mask_r};
            default:          rd_byte = 8'h00;
        endcase
    end

    // Configuration registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_enable_r        <= 1'(`RST_CONFIG_A >> `CFGA_EN_BIT);
            offset_select_r           <= sdadc_pkg::ofs_sel_t'(2'(`RST_CONFIG_B >> `CFGB_OFS_LSB));
            oversample_ratio_select_r <= 3'(`RST_CONFIG_B >> `CFGB_OSR_LSB);
            conv_clock_select_r       <= 3'(`RST_CONFIG_C >> `CFGC_KS_LSB);
            conv_clock_invert_r       <= 1'(`RST_CONFIG_C >> `CFGC_INV_BIT);
            chopper_enable_r          <= 1'(`RST_CONFIG_C >> `CFGC_CHOP_BIT);
            irq_mask_r                <= `RST_IRQ;
        end else begin
            if (wr_to(`IDX_CONFIG_A)) begin
                converter_enable_r <= wb_dat_i[`CFGA_EN_BIT];
            end
            if (wr_to(`IDX_CONFIG_B)) begin
                offset_select_r           <= sdadc_pkg::ofs_sel_t'(wb_dat_i[`CFGB_OFS_LSB +: 2]);
                oversample_ratio_select_r <= wb_dat_i[`CFGB_OSR_LSB +: 3];
            end
            if (wr_to(`IDX_CONFIG_C)) begin
                conv_clock_select_r <= wb_dat_i[`CFGC_KS_LSB +: 3];
                conv_clock_invert_r <= wb_dat_i[`CFGC_INV_BIT];
                chopper_enable_r    <= wb_dat_i[`CFGC_CHOP_BIT];
            end
            if (wr_to(`IDX_IRQ_MASK)) begin
                irq_mask_r <= wb_dat_i[2:0];
            end
        end
    end

    // Ready flag: a new word wins over a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_ready_flag_r <= 1'b0;
        end else if (dbus.word_valid) begin
            conv_ready_flag_r <= 1'b1;
        end else if (wr_to(`IDX_CONFIG_B) && !wb_dat_i[`CFGB_RDY_BIT]) begin
            conv_ready_flag_r <= 1'b0;
        end
    end

    // Result bytes load only from the decimator, all three at once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= `RST_RESULT;
        end else if (dbus.word_valid) begin
            result_r <= dbus.word;
        end
    end

    // Words since enable; the third and later count as settled.
    always_ff @(posedge clk_i) begin
        if (rst_i || !converter_enable_r) begin
            settle_cnt_r <= 2'd0;
        end else if (dbus.word_valid && settle_cnt_r != 2'(`SETTLE_WORDS - 1)) begin
            settle_cnt_r <= settle_cnt_r + 2'd1;
        end
    end

    assign irq_set[`IRQ_WORD_BIT]    = dbus.word_valid;
    assign irq_set[`IRQ_SAT_BIT]     = dbus.word_valid && dbus.sat;
    assign irq_set[`IRQ_SETTLED_BIT] = dbus.word_valid && settle_cnt_r == 2'(`SETTLE_WORDS - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_r <= `RST_IRQ;
            irq_o        <= 1'b0;
        end else begin
            irq_status_r <= irq_set | (irq_status_r & ~(wr_to(`IDX_IRQ_STATUS) ? wb_dat_i[2:0] : 3'd0));
            irq_o        <= |(irq_status_r & irq_mask_r);
        end
    end

    // Modulator bit crosses in from the analogue side.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_meta_r <= 1'b0;
            mod_sync_r <= 1'b0;
        end else begin
            mod_meta_r <= mod_bit_i;
            mod_sync_r <= mod_meta_r;
        end
    end

    // Converter clock: half period of 50 system cycles at 250 kHz, doubled per code step up to 011; 1xx gives 50.
    assign half_len  = (conv_clock_select_r[2] ? 9'(`CONV_HALF_CYCLES)
                                               : 9'(`CONV_HALF_CYCLES) << conv_clock_select_r[1:0]);
    assign half_tick = converter_enable_r && (div_cnt_r == half_len - 9'd1);

    always_ff @(posedge clk_i) begin
        if (rst_i || !converter_enable_r) begin
            div_cnt_r      <= 9'd0;
            conv_clk_o     <= 1'b0;
            dbus.sample_en <= 1'b0;
            dbus.mod_bit   <= 1'b0;
        end else begin
            div_cnt_r      <= half_tick ? 9'd0 : div_cnt_r + 9'd1;
            dbus.sample_en <= half_tick && ((!conv_clk_o) ^ conv_clock_invert_r);
            if (half_tick) begin
                conv_clk_o   <= !conv_clk_o;
                dbus.mod_bit <= mod_sync_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_enable_o  <= 1'b0;
            chopper_enable_o    <= 1'b1;
            conv_clock_invert_o <= 1'b0;
            dbus.run            <= 1'b0;
            dbus.osr_sel        <= 3'b111;
            dbus.ofs_sel        <= sdadc_pkg::OFS_0;
        end else begin
            converter_enable_o  <= converter_enable_r;
            chopper_enable_o    <= chopper_enable_r;
            conv_clock_invert_o <= conv_clock_invert_r;
            dbus.run            <= converter_enable_r;
            dbus.osr_sel        <= oversample_ratio_select_r;
            dbus.ofs_sel        <= offset_select_r;
        end
    end

    // Helper: cycles since the converter clock last toggled.
    logic [9:0] tog_gap_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !converter_enable_r || half_tick) begin
            tog_gap_r <= 10'd0;
        end else begin
            tog_gap_r <= tog_gap_r + 10'd1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_new_word;
        dbus.word_valid;
    endsequence

    AST_READY_SET: assert property (s_new_word |=> conv_ready_flag_r)
        else $error("Ready flag not set by a new word.");
    AST_READY_HOLD: assert property (conv_ready_flag_r && !(wr_to(`IDX_CONFIG_B) && !wb_dat_i[0]) |=> conv_ready_flag_r)
        else $error("Ready flag dropped without a software clear.");
    AST_RESULT_SPLIT: assert property (s_new_word |=> result_r == $past(dbus.word))
        else $error("Result bytes not loaded together.");
    AST_RESULT_RO: assert property (!dbus.word_valid |=> $stable(result_r))
        else $error("Result changed without a new word.");
    AST_CLK_HALF: assert property (half_tick |-> tog_gap_r == 10'(half_len - 9'd1))
        else $error("Converter clock half period wrong.");
    AST_DISABLED_QUIET: assert property (!converter_enable_r |=> !dbus.sample_en ##1 !dbus.word_valid)
        else $error("Samples while converter disabled.");
    AST_SETTLED_THIRD: assert property ($rose(irq_status_r[`IRQ_SETTLED_BIT]) |-> $past(settle_cnt_r) == 2'd2)
        else $error("Settled event before the third word.");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack held for more than one cycle.");
    AST_IRQ_LEVEL: assert property (##1 irq_o == $past(|(irq_status_r & irq_mask_r)))
        else $error("Interrupt does not follow masked status.");

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_read_of(logic [7:0] target);
        s_bus_req ##0 (!wb_we_i && idx == target);
    endsequence

    sequence s_ready_clear;
        wr_to(`IDX_CONFIG_B) && !wb_dat_i[`CFGB_RDY_BIT] && !dbus.word_valid;
    endsequence

    AST_ACK_NEXT: assert property (s_bus_req |=> wb_ack_o)
        else $error("Request not answered in the next cycle.");
    AST_READY_CLEAR: assert property (s_ready_clear |=> !conv_ready_flag_r)
        else $error("Ready flag not cleared by software.");
    AST_READ_HIGH: assert property (s_read_of(`IDX_RESULT_HIGH) |=>
        wb_dat_o[7:0] == $past(result_r[23:16]))
        else $error("High result byte read wrong.");
    AST_READ_MID: assert property (s_read_of(`IDX_RESULT_MID) |=>
        wb_dat_o[7:0] == $past(result_r[15:8]))
        else $error("Middle result byte read wrong.");
    AST_READ_LOW: assert property (s_read_of(`IDX_RESULT_LOW) |=>
        wb_dat_o[7:0] == $past(result_r[7:0]))
        else $error("Low result byte read wrong.");
    AST_READ_UPPER_ZERO: assert property (s_bus_req ##0 !wb_we_i |=> wb_dat_o[31:8] == 24'h00_0000)
        else $error("Upper read data bits not zero.");
    AST_CLK_OFF_LOW: assert property (!converter_enable_r |=> !conv_clk_o)
        else $error("Converter clock high while disabled.");
    AST_OSR_WRITE: assert property (wr_to(`IDX_CONFIG_B) |=>
        oversample_ratio_select_r == $past(wb_dat_i[`CFGB_OSR_LSB +: 3]))
        else $error("Ratio select not written.");
    AST_CHOP_FOLLOW: assert property (##1 chopper_enable_o == $past(chopper_enable_r))
        else $error("Chopper output does not follow its bit.");
    AST_SETTLE_RESET: assert property (!converter_enable_r |=> settle_cnt_r == 2'd0)
        else $error("Settle count kept while disabled.");
    AST_IRQ_CLEAR: assert property (wr_to(`IDX_IRQ_STATUS) && wb_dat_i[`IRQ_WORD_BIT] && !dbus.word_valid |=>
        !irq_status_r[`IRQ_WORD_BIT])
        else $error("Word status bit not cleared by a one.");
    AST_SAT_EVENT: assert property (s_new_word ##0 dbus.sat |=> irq_status_r[`IRQ_SAT_BIT])
        else $error("Saturated word not flagged.");
endmodule : sigma_delta_adc_result_ctrl

// ===== tb/sdadc_front_model.sv
// Purpose: Behavioural modulator bitstream source at the far side of the converter.
// Assumes: The bit changes after a falling converter clock, so it is stable at the rising one.
// Notes:   Mode 0 mid-scale pattern, 1 all ones, 2 all zeros.
`timescale 1ns/10ps
module sdadc_front_model (
    input  wire logic       clk_i,
    input  wire logic       conv_clk_i,
    input  wire logic       enable_i,
    input  wire logic [1:0] mode_i,
    output logic            mod_bit_o
);
    logic conv_clk_q_r;
    logic bit_r = 1'b0;

    assign mod_bit_o = bit_r;

    always @(posedge clk_i) begin
        conv_clk_q_r <= conv_clk_i;
        if (!enable_i) begin
            // While stopped a steady mode holds its level so the first sample is already right.
            bit_r <= (mode_i == 2'd1) ? 1'b1 : (mode_i == 2'd2) ? 1'b0 : ~bit_r;
        end else if (conv_clk_q_r && !conv_clk_i) begin
            case (mode_i)
                2'd1:    bit_r <= 1'b1;
                2'd2:    bit_r <= 1'b0;
                default: bit_r <= ~bit_r;
            endcase
        end
    end
endmodule : sdadc_front_model

// ===== tb/tb_sigma_delta_adc_result_ctrl.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Classic Wishbone master, one idle cycle between requests.
// Notes:   Word periods use the fastest clock and ratio 64, one value check ratio 128, to keep the run short.
`include "sdadc_defs.svh"
`timescale 1ns/10ps
module tb_sigma_delta_adc_result_ctrl;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, mod_bit, conv_clk, conv_en, chop_en, clk_inv, irq;
    logic [9:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [1:0]  mode;
    int          miscompares, n_checks;
    int          cyc_cnt = 0;

    sigma_delta_adc_result_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .mod_bit_i(mod_bit), .conv_clk_o(conv_clk), .converter_enable_o(conv_en),
        .chopper_enable_o(chop_en), .conv_clock_invert_o(clk_inv), .irq_o(irq));
    sdadc_front_model front (.clk_i(clk_i), .conv_clk_i(conv_clk), .enable_i(conv_en), .mode_i(mode),
        .mod_bit_o(mod_bit));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_adr   <= {idx, 2'b00};
        wb_sel   <= s;
        wb_dat_w <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        chk(32'(wb_dat_r[31:8]), 32'h0000_0000);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 4'h1);
    endtask : wr

    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, 4'hf);
        chk(q, {24'h00_0000, exp});
    endtask : chk_rd

    task automatic wait_ready(output int t);
        int n;
        for (n = 0; n < 6000; n++) begin
            xfer(1'b0, `IDX_CONFIG_B, 8'h00, 4'hf);
            if (q[0] === 1'b1) break;
        end
        t = cyc_cnt;
        chk(32'(q[0]), 32'h0000_0001);
    endtask : wait_ready

    task automatic read_result(output logic [23:0] r);
        xfer(1'b0, `IDX_RESULT_HIGH, 8'h00, 4'hf);
        r[23:16] = q[7:0];
        xfer(1'b0, `IDX_RESULT_MID, 8'h00, 4'hf);
        r[15:8] = q[7:0];
        xfer(1'b0, `IDX_RESULT_LOW, 8'h00, 4'hf);
        r[7:0] = q[7:0];
    endtask : read_result

    task automatic test_reset();
        chk_rd(`IDX_CONFIG_A, 8'h00);
        chk_rd(`IDX_CONFIG_B, 8'h76);
        chk_rd(`IDX_CONFIG_C, 8'h10);
        for (int i = 0; i < 3; i++) chk_rd(8'(8'h97 + i), 8'h00);
        chk_rd(`IDX_IRQ_STATUS, 8'h00);
        chk_rd(`IDX_IRQ_MASK, 8'h00);
        chk(32'({chop_en, clk_inv, conv_en, irq}), 32'h0000_0008);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_regs();
        wr(`IDX_CONFIG_B, 8'h89);
        chk_rd(`IDX_CONFIG_B, 8'h00);
        wr(`IDX_CONFIG_C, 8'hff);
        chk_rd(`IDX_CONFIG_C, 8'h1f);
        chk(32'(clk_inv), 32'h0000_0001);
        xfer(1'b1, `IDX_CONFIG_C, 8'h10, 4'h0);
        chk_rd(`IDX_CONFIG_C, 8'h1f);
        wr(`IDX_CONFIG_C, 8'h10);
        @(negedge clk_i);
        chk(32'(clk_inv), 32'h0000_0000);
        for (int i = 0; i < 3; i++) wr(8'(8'h97 + i), 8'h5a);
        for (int i = 0; i < 3; i++) chk_rd(8'(8'h97 + i), 8'h00);
        wr(8'h20, 8'hff);
        chk_rd(8'h20, 8'h00);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_clock();
        int n, r0, r1;
        logic prev;
        for (int s = 0; s < 8; s++) begin
            wr(`IDX_CONFIG_A, 8'h00);
            wr(`IDX_CONFIG_C, 8'(8'h10 | s));
            wr(`IDX_CONFIG_A, 8'h01);
            prev = conv_clk;
            r0 = -1;
            r1 = -1;
            for (n = 0; n < 2500 && r1 < 0; n++) begin
                @(negedge clk_i);
                if (!prev && conv_clk === 1'b1) begin
                    if (r0 < 0) r0 = n;
                    else r1 = n;
                end
                prev = conv_clk;
            end
            chk(r1 - r0, (s > 3) ? 100 : 100 << s);
        end
        wr(`IDX_CONFIG_A, 8'h00);
        wr(`IDX_CONFIG_C, 8'h10);
        for (n = 0; n < 200; n++) begin
            @(negedge clk_i);
            if (conv_clk !== 1'b0) break;
        end
        chk(n, 200);
        $display("test_clock done");
    endtask : test_clock

    task automatic test_stream();
        int t, tp;
        logic [23:0] r;
        mode <= 2'd0;
        wr(`IDX_CONFIG_B, 8'h06);
        wr(`IDX_IRQ_STATUS, 8'h07);
        wr(`IDX_IRQ_MASK, 8'h01);
        wr(`IDX_CONFIG_A, 8'h01);
        tp = 0;
        for (int w = 1; w < 4; w++) begin
            wait_ready(t);
            if (w > 1) chk(32'(t - tp > 6394 && t - tp < 6406), 32'h0000_0001);
            tp = t;
            chk_rd(`IDX_IRQ_STATUS, (w == 3) ? 8'h05 : 8'h01);
            chk(32'(irq), 32'h0000_0001);
            read_result(r);
            chk(32'(r), 32'h0000_0000);
            chk_rd(`IDX_CONFIG_B, 8'h07);
            wr(`IDX_IRQ_STATUS, 8'h07);
            wr(`IDX_CONFIG_B, 8'h06);
            chk_rd(`IDX_CONFIG_B, 8'h06);
            chk(32'(irq), 32'h0000_0000);
        end
        wr(`IDX_CONFIG_A, 8'h00);
        $display("test_stream done");
    endtask : test_stream

    task automatic test_values();
        logic [23:0] exp_t [7] = '{24'hA0_0000, 24'hC0_0000, 24'hE0_0000, 24'h00_0000, 24'h7F_FFF0,
                                   24'h80_0000, 24'h00_0000};
        logic [7:0]  cfg_t [7] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h06, 8'h04, 8'h16};
        logic [23:0] r;
        int t0, t, lat;
        for (int i = 0; i < 7; i++) begin
            wr(`IDX_CONFIG_A, 8'h00);
            mode <= (i == 4) ? 2'd1 : (i == 5) ? 2'd2 : 2'd0;
            wr(`IDX_CONFIG_B, cfg_t[i]);
            wr(`IDX_IRQ_STATUS, 8'h07);
            wr(`IDX_CONFIG_A, 8'h01);
            t0 = cyc_cnt;
            wait_ready(t);
            lat = (i == 6) ? 12800 : 6400;
            chk(32'(t - t0 > lat - 100 && t - t0 < lat + 20), 32'h0000_0001);
            read_result(r);
            chk(32'(r), 32'(exp_t[i]));
            xfer(1'b0, `IDX_IRQ_STATUS, 8'h00, 4'hf);
            chk(32'(q[1]), (i == 4 || i == 5) ? 32'h1 : 32'h0);
        end
        wr(`IDX_CONFIG_A, 8'h00);
        $display("test_values done");
    endtask : test_values

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial begin
        repeat (95000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
        rst_i = 1'b1;
        mode = 2'd0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_regs();
        test_clock();
        test_stream();
        test_values();
        complete_run();
    end
endmodule : tb_sigma_delta_adc_result_ctrl
